// ==== design/bpcr_defs.svh ====
`ifndef BPCR_DEFS_SVH
`define BPCR_DEFS_SVH

// Register indices; byte address is four times the index
`define BPCR_IDX_C3_CTL1   15'h4060
`define BPCR_IDX_C3_CTL2   15'h4061
`define BPCR_IDX_C3_ON     15'h4062
`define BPCR_IDX_C3_SLEEP  15'h4063
`define BPCR_IDX_C4_CTL1   15'h4064
`define BPCR_IDX_C4_CTL2   15'h4065
`define BPCR_IDX_C4_ON     15'h4066
`define BPCR_IDX_C4_SLEEP  15'h4067
`define BPCR_IDX_KEY       15'h4070

// Reset values
`define BPCR_RST_CTL1      16'h0014
`define BPCR_RST_CTL2      16'h0300
`define BPCR_RST_CFG       16'h0000

// Software write masks
`define BPCR_WM_CTL1       16'h10f0
`define BPCR_WM_CTL2       16'hdf80
`define BPCR_WM_CFG        16'he37f
`define BPCR_WM_LIM        16'h000c

// Field positions
`define BPCR_LD_CAP        16'h0003
`define BPCR_LD_ON_HI      16'h007c
`define BPCR_LD_SLAVE      16'h2003
`define BPCR_BIT_SLAVE     13
`define BPCR_BIT_OVP       7

// User key unlock word, value is arbitrary
`define BPCR_KEY_VALUE     16'h5a3c

// Voltage coding in millivolts
`define BPCR_VMIN_MV       12'h352
`define BPCR_VSTEP_MV      12'h019
`define BPCR_VMAX_MV       12'hd48
`define BPCR_VSAT_CODE     7'h66

// Current limit decode in milliamps
`define BPCR_ILIM_0        9'h032
`define BPCR_ILIM_1        9'h064
`define BPCR_ILIM_2        9'h0c8
`define BPCR_ILIM_3        9'h190

// Soft-start step times
`define BPCR_CLK_MHZ       50
`define BPCR_SS_T1_US      512
`define BPCR_SS_T2_US      4096
`define BPCR_SS_T3_US      32768

`endif

// ==== design/bpcr_pkg.sv ====
package bpcr_pkg;
    typedef logic [15:0] bpcr_word_t;
    typedef enum logic [1:0] {
        BPCR_SS_IDLE = 2'b01,
        BPCR_SS_RAMP = 2'b10
    } bpcr_ss_state_t;
endpackage : bpcr_pkg

// ==== design/bpcr_conv_ctrl.sv ====
`timescale 1ns/100ps
`include "bpcr_defs.svh"
module bpcr_conv_ctrl
    import bpcr_pkg::*;
#(
    parameter int SS1_CYC = `BPCR_SS_T1_US * `BPCR_CLK_MHZ,
    parameter int SS2_CYC = `BPCR_SS_T2_US * `BPCR_CLK_MHZ,
    parameter int SS3_CYC = `BPCR_SS_T3_US * `BPCR_CLK_MHZ
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // Settings
    input  wire logic [6:0]  on_code,
    input  wire logic [6:0]  sleep_code,
    input  wire logic [1:0]  ilim_sel,
    input  wire logic [1:0]  ss_sel,
    input  wire logic        start,
    // Decoded outputs
    output logic      [11:0] on_mv,
    output logic      [11:0] sleep_mv,
    output logic      [8:0]  ilim_ma,
    output logic      [1:0]  ss_step,
    output logic             ss_busy
);
    localparam logic [20:0] D1 = 21'(SS1_CYC - 1);
    localparam logic [20:0] D2 = 21'(SS2_CYC - 1);
    localparam logic [20:0] D3 = 21'(SS3_CYC - 1);

    bpcr_ss_state_t state_r;
    logic [20:0]    cnt_r;
    logic [20:0]    dur_r;

    // Linear code to millivolts, saturating at the top
    wire [11:0] on_lin  = `BPCR_VMIN_MV + 12'(on_code) * `BPCR_VSTEP_MV;
    wire [11:0] slp_lin = `BPCR_VMIN_MV + 12'(sleep_code) * `BPCR_VSTEP_MV;
    wire [11:0] on_nxt  = (on_code >= `BPCR_VSAT_CODE) ? `BPCR_VMAX_MV : on_lin;
    wire [11:0] slp_nxt = (sleep_code >= `BPCR_VSAT_CODE) ? `BPCR_VMAX_MV : slp_lin;
    wire [8:0]  ilim_nxt = (ilim_sel == 2'h0) ? `BPCR_ILIM_0 :
                           (ilim_sel == 2'h1) ? `BPCR_ILIM_1 :
                           (ilim_sel == 2'h2) ? `BPCR_ILIM_2 : `BPCR_ILIM_3;
    wire [20:0] dur_sel = (ss_sel == 2'h1) ? D1 : (ss_sel == 2'h2) ? D2 : D3;
    wire        cnt_end = (cnt_r == 21'h0);

    // Decode registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            on_mv    <= `BPCR_VMIN_MV;
            sleep_mv <= `BPCR_VMIN_MV;
            ilim_ma  <= `BPCR_ILIM_1;
        end else begin
            on_mv    <= on_nxt;
            sleep_mv <= slp_nxt;
            ilim_ma  <= ilim_nxt;
        end
    end

    // Soft-start: three timed limiting steps, then full current
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= BPCR_SS_IDLE;
            cnt_r   <= 21'h0;
            dur_r   <= 21'h0;
            ss_step <= 2'h0;
            ss_busy <= 1'b0;
        end else begin
            unique case (state_r)
                BPCR_SS_IDLE: begin
                    if (start && ss_sel != 2'h0) begin
                        state_r <= BPCR_SS_RAMP;
                        cnt_r   <= dur_sel;
                        dur_r   <= dur_sel;
                        ss_step <= 2'h1;
                        ss_busy <= 1'b1;
                    end
                end
                BPCR_SS_RAMP: begin
                    if (!cnt_end) begin
                        cnt_r <= cnt_r - 21'h1;
                    end else if (ss_step == 2'h3) begin
                        state_r <= BPCR_SS_IDLE;
                        ss_step <= 2'h0;
                        ss_busy <= 1'b0;
                    end else begin
                        cnt_r   <= dur_r;
                        ss_step <= ss_step + 2'h1;
                    end
                end
            endcase
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    chk_ilim_top: assert property (ilim_sel == 2'h3 |=> ilim_ma == 9'h190)
        else $error("limit code 3 not 400mA");
    chk_ilim_low: assert property (ilim_sel == 2'h2 |=> ilim_ma == 9'h0c8)
        else $error("limit code 2 not 200mA");
    chk_on_linear: assert property (on_code == 7'h01 |=> on_mv == 12'h36b)
        else $error("on code 1 not 875mV");
    chk_sleep_sat: assert property (sleep_code > 7'h65 |=> sleep_mv == 12'hd48)
        else $error("sleep code not saturated");
    chk_ss_immediate: assert property (
        start && ss_sel == 2'h0 && !ss_busy |=> (!ss_busy) [*3])
        else $error("immediate start ran steps");
    chk_ss_step_len: assert property (
        $rose(ss_busy) |-> cnt_r == dur_r && ss_step == 2'h1)
        else $error("first step length wrong");
    cov_ss_done: cover property (ss_step == 2'h3 ##1 !ss_busy);
endmodule : bpcr_conv_ctrl

// ==== design/bpcr_regs.sv ====
`timescale 1ns/100ps
`include "bpcr_defs.svh"
module bpcr_regs
    import bpcr_pkg::*;
#(
    parameter int SS1_CYC = `BPCR_SS_T1_US * `BPCR_CLK_MHZ,
    parameter int SS2_CYC = `BPCR_SS_T2_US * `BPCR_CLK_MHZ,
    parameter int SS3_CYC = `BPCR_SS_T3_US * `BPCR_CLK_MHZ
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    // Avalon-MM slave
    input  wire logic [16:0]       avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    // Configuration load from OTP or external EEPROM
    input  wire logic              cfg_load,
    input  wire logic [1:0]        cfg_conv3_cap,
    input  wire logic [1:0]        cfg_conv4_cap,
    input  wire logic              cfg_conv4_slave,
    input  wire logic [4:0]        cfg_conv3_on_hi,
    input  wire logic [4:0]        cfg_conv4_on_hi,
    // Converter start requests
    input  wire logic [1:0]        conv_start,
    // Converter settings
    output logic      [1:0]        conv3_output_cap_range,
    output logic      [1:0]        conv4_output_cap_range,
    output logic                   conv3_overvoltage_protect_en,
    output logic                   conv4_overvoltage_protect_en,
    output logic                   conv4_slave_select,
    output logic                   key_unlocked,
    // Decoded converter state
    output logic      [1:0][11:0]  conv_on_mv,
    output logic      [1:0][11:0]  conv_sleep_mv,
    output logic      [1:0][8:0]   conv_ilim_ma,
    output logic      [1:0][1:0]   conv_ss_step,
    output logic      [1:0]        conv_ss_busy
);
    localparam int NREG = 8;

    localparam logic [14:0] REG_IDX [NREG] = '{
        `BPCR_IDX_C3_CTL1, `BPCR_IDX_C3_CTL2, `BPCR_IDX_C3_ON, `BPCR_IDX_C3_SLEEP,
        `BPCR_IDX_C4_CTL1, `BPCR_IDX_C4_CTL2, `BPCR_IDX_C4_ON, `BPCR_IDX_C4_SLEEP
    };
    localparam bpcr_word_t REG_RST [NREG] = '{
        `BPCR_RST_CTL1, `BPCR_RST_CTL2, `BPCR_RST_CFG, `BPCR_RST_CFG,
        `BPCR_RST_CTL1, `BPCR_RST_CTL2, `BPCR_RST_CFG, `BPCR_RST_CFG
    };
    localparam bpcr_word_t REG_WM [NREG] = '{
        `BPCR_WM_CTL1, `BPCR_WM_CTL2, `BPCR_WM_CFG, `BPCR_WM_CFG,
        `BPCR_WM_CTL1, `BPCR_WM_CTL2, `BPCR_WM_CFG, `BPCR_WM_CFG
    };

    bpcr_word_t        reg_r   [NREG];
    bpcr_word_t        reg_nxt [NREG];
    bpcr_word_t        ld_mask [NREG];
    bpcr_word_t        ld_val  [NREG];
    logic [NREG-1:0]   hit;
    bpcr_word_t        rd_word;
    logic              eff_ovp4;

    // Bus decode; registers answer one wait cycle after a request
    wire [14:0]  word_idx = avs_address[16:2];
    wire         aligned  = (avs_address[1:0] == 2'h0);
    wire         req      = avs_read | avs_write;
    wire         wr_go    = avs_write & ~avs_waitrequest;
    wire         key_hit  = aligned & (word_idx == `BPCR_IDX_KEY);
    wire [15:0]  be_mask  = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [15:0]  wdata    = avs_writedata[15:0];

    // Configuration load masks and values
    assign ld_mask[0] = `BPCR_LD_CAP;
    assign ld_val[0]  = {14'h0, cfg_conv3_cap};
    assign ld_mask[1] = 16'h0;
    assign ld_val[1]  = 16'h0;
    assign ld_mask[2] = `BPCR_LD_ON_HI;
    assign ld_val[2]  = {9'h0, cfg_conv3_on_hi, 2'h0};
    assign ld_mask[3] = 16'h0;
    assign ld_val[3]  = 16'h0;
    assign ld_mask[4] = `BPCR_LD_SLAVE;
    assign ld_val[4]  = {2'h0, cfg_conv4_slave, 11'h0, cfg_conv4_cap};
    assign ld_mask[5] = 16'h0;
    assign ld_val[5]  = 16'h0;
    assign ld_mask[6] = `BPCR_LD_ON_HI;
    assign ld_val[6]  = {9'h0, cfg_conv4_on_hi, 2'h0};
    assign ld_mask[7] = 16'h0;
    assign ld_val[7]  = 16'h0;

    // Per-register decode, masked write and load merge
    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++) begin : g_reg
            wire [15:0] lim_wm = (gi == 0 || gi == 4) && key_unlocked ?
                                 `BPCR_WM_LIM : 16'h0;
            wire [15:0] wm     = (REG_WM[gi] | lim_wm) & be_mask;
            wire        wr_hit = wr_go & hit[gi];
            wire [15:0] wr_val = wr_hit ? (reg_r[gi] & ~wm) | (wdata & wm) : reg_r[gi];
            assign hit[gi] = aligned & (word_idx == REG_IDX[gi]);
            assign reg_nxt[gi] = cfg_load ?
                (wr_val & ~ld_mask[gi]) | (ld_val[gi] & ld_mask[gi]) : wr_val;
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    reg_r[gi] <= REG_RST[gi];
                end else begin
                    reg_r[gi] <= reg_nxt[gi];
                end
            end
        end
    endgenerate

    // Read data selection, unmapped reads as zero
    always_comb begin
        rd_word = key_hit ? {15'h0, key_unlocked} : 16'h0;
        for (int i = 0; i < NREG; i++) begin
            if (hit[i]) begin
                rd_word = reg_r[i];
            end
        end
    end

    // Bus handshake and read capture
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0;
        end else begin
            avs_waitrequest <= ~(req & avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                avs_readdata <= {16'h0, rd_word};
            end
        end
    end

    // User key: a write of the unlock word with both low byte enables opens, any other such write closes
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            key_unlocked <= 1'b0;
        end else if (wr_go && key_hit && avs_byteenable[1:0] == 2'h3) begin
            key_unlocked <= (wdata == `BPCR_KEY_VALUE);
        end
    end

    // Slave mode steers converter four from converter three registers
    wire        slave    = reg_r[4][`BPCR_BIT_SLAVE];
    wire [15:0] c4_ctl1  = slave ? reg_r[0] : reg_r[4];
    wire [15:0] c4_ctl2  = slave ? reg_r[1] : reg_r[5];
    wire [15:0] c4_on    = slave ? reg_r[2] : reg_r[6];
    wire [15:0] c4_sleep = slave ? reg_r[3] : reg_r[7];
    wire        c4_start = slave ? conv_start[0] : conv_start[1];
    assign eff_ovp4 = c4_ctl2[`BPCR_BIT_OVP];

    // Registered settings outputs
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            conv3_output_cap_range       <= 2'h0;
            conv4_output_cap_range       <= 2'h0;
            conv3_overvoltage_protect_en <= 1'b0;
            conv4_overvoltage_protect_en <= 1'b0;
            conv4_slave_select           <= 1'b0;
        end else begin
            conv3_output_cap_range       <= reg_r[0][1:0];
            conv4_output_cap_range       <= c4_ctl1[1:0];
            conv3_overvoltage_protect_en <= reg_r[1][`BPCR_BIT_OVP];
            conv4_overvoltage_protect_en <= eff_ovp4;
            conv4_slave_select           <= slave;
        end
    end

    // Decoders and soft-start sequencers, one per converter
    bpcr_conv_ctrl #(
        .SS1_CYC (SS1_CYC),
        .SS2_CYC (SS2_CYC),
        .SS3_CYC (SS3_CYC)
    ) u_conv3 (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .on_code    (reg_r[2][6:0]),
        .sleep_code (reg_r[3][6:0]),
        .ilim_sel   (reg_r[0][3:2]),
        .ss_sel     (reg_r[0][5:4]),
        .start      (conv_start[0]),
        .on_mv      (conv_on_mv[0]),
        .sleep_mv   (conv_sleep_mv[0]),
        .ilim_ma    (conv_ilim_ma[0]),
        .ss_step    (conv_ss_step[0]),
        .ss_busy    (conv_ss_busy[0])
    );

    bpcr_conv_ctrl #(
        .SS1_CYC (SS1_CYC),
        .SS2_CYC (SS2_CYC),
        .SS3_CYC (SS3_CYC)
    ) u_conv4 (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .on_code    (c4_on[6:0]),
        .sleep_code (c4_sleep[6:0]),
        .ilim_sel   (c4_ctl1[3:2]),
        .ss_sel     (c4_ctl1[5:4]),
        .start      (c4_start),
        .on_mv      (conv_on_mv[1]),
        .sleep_mv   (conv_sleep_mv[1]),
        .ilim_ma    (conv_ilim_ma[1]),
        .ss_step    (conv_ss_step[1]),
        .ss_busy    (conv_ss_busy[1])
    );

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    chk_cap_readonly: assert property (
        !cfg_load |=> reg_r[0][1:0] == $past(reg_r[0][1:0]))
        else $error("cap range changed without load");
    chk_slave_readonly: assert property (
        !cfg_load |=> reg_r[4][13] == $past(reg_r[4][13]))
        else $error("slave bit changed without load");
    chk_load_on_hi: assert property (
        cfg_load && !wr_go |=> reg_r[2][6:2] == $past(cfg_conv3_on_hi)
                            && reg_r[2][1:0] == $past(reg_r[2][1:0]))
        else $error("load did not set on code bits");
    chk_lim_locked: assert property (
        !key_unlocked |=> reg_r[0][3:2] == $past(reg_r[0][3:2])
                       && reg_r[4][3:2] == $past(reg_r[4][3:2]))
        else $error("limit changed while locked");
    chk_lim_other: assert property (
        wr_go && hit[0] && !key_unlocked && avs_byteenable[0] |=>
        reg_r[0][5:4] == $past(wdata[5:4]))
        else $error("locked write dropped soft-start");
    chk_slave_follow: assert property (
        slave ##1 slave [*2] |-> conv_on_mv[1] == conv_on_mv[0])
        else $error("slave converter not following");
    chk_slave_out: assert property (
        slave ##1 slave |-> conv4_output_cap_range == $past(reg_r[0][1:0]))
        else $error("slave cap range not from conv3");
    chk_wait_one: assert property (
        req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest not one cycle low");

    cov_key_write: cover property (key_unlocked ##1 wr_go && hit[0]);
    cov_load: cover property (cfg_load && cfg_conv4_slave);
    cov_read: cover property (avs_read && !avs_waitrequest && hit[2]);
endmodule : bpcr_regs

// ==== dv/bpcr_regs_tb.sv ====
`timescale 1ns/100ps
`include "bpcr_defs.svh"
module bpcr_regs_tb
    import bpcr_pkg::*;
;
    // Clock, reset and bus
    logic              sys_clk;
    logic              rstn;
    logic [16:0]       avs_address;
    logic              avs_read;
    logic              avs_write;
    logic [31:0]       avs_writedata;
    logic [3:0]        avs_byteenable;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    // Configuration load and start
    logic              cfg_load;
    logic [1:0]        cfg_conv3_cap;
    logic [1:0]        cfg_conv4_cap;
    logic              cfg_conv4_slave;
    logic [4:0]        cfg_conv3_on_hi;
    logic [4:0]        cfg_conv4_on_hi;
    logic [1:0]        conv_start;
    // Observed settings
    logic [1:0]        cap3;
    logic [1:0]        cap4;
    logic              ovp3;
    logic              ovp4;
    logic              slave;
    logic              key_unlocked;
    logic [1:0][11:0]  conv_on_mv;
    logic [1:0][11:0]  conv_sleep_mv;
    logic [1:0][8:0]   conv_ilim_ma;
    logic [1:0][1:0]   conv_ss_step;
    logic [1:0]        conv_ss_busy;
    // Bench bookkeeping
    int                err_count = 0;
    int                n_compared = 0;
    bpcr_word_t        rd;
    logic [8:0]        ilim_tab [4] = '{9'h032, 9'h064, 9'h0c8, 9'h190};
    logic [31:0]       ss_exp   [4] = '{32'h0, 32'h0c, 32'h18, 32'h30};
    logic [6:0]        vcode    [4] = '{7'h00, 7'h01, 7'h65, 7'h66};

    // Short soft-start steps: 4, 8 and 16 cycles
    bpcr_regs #(.SS1_CYC(4), .SS2_CYC(8), .SS3_CYC(16)) i_dut (
        .sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cfg_load(cfg_load),
        .cfg_conv3_cap(cfg_conv3_cap), .cfg_conv4_cap(cfg_conv4_cap),
        .cfg_conv4_slave(cfg_conv4_slave), .cfg_conv3_on_hi(cfg_conv3_on_hi),
        .cfg_conv4_on_hi(cfg_conv4_on_hi), .conv_start(conv_start),
        .conv3_output_cap_range(cap3), .conv4_output_cap_range(cap4),
        .conv3_overvoltage_protect_en(ovp3), .conv4_overvoltage_protect_en(ovp4),
        .conv4_slave_select(slave), .key_unlocked(key_unlocked),
        .conv_on_mv(conv_on_mv), .conv_sleep_mv(conv_sleep_mv),
        .conv_ilim_ma(conv_ilim_ma), .conv_ss_step(conv_ss_step),
        .conv_ss_busy(conv_ss_busy));

    // Clock at 50 MHz
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // Expected output level for a voltage code, saturating at the top
    function automatic logic [31:0] mv_of(input logic [6:0] c);
        mv_of = (c >= 7'h66) ? 32'h0000_0d48 : 32'h0000_0352 + 32'h19 * {25'h0, c};
    endfunction : mv_of

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One bus request held until waitrequest is seen low at a rising edge
    task automatic bus_xfer(input logic wr, input logic [14:0] idx, input bpcr_word_t d,
                            input logic [3:0] be, output bpcr_word_t q);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address    <= {idx, 2'b00};
        avs_writedata  <= {16'h0, d};
        avs_byteenable <= be;
        avs_write      <= wr;
        avs_read       <= ~wr;
        // Waitrequest and read data are taken at the rising edge itself
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        if (n >= 100) chk("bus_answer", 32'h0, 32'h1);
        if (!wr) chk("upper_half", 32'h0, {avs_readdata[31:16], 16'h0});
        q = avs_readdata[15:0];
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus_xfer

    task automatic wr16(input logic [14:0] idx, input bpcr_word_t d);
        bpcr_word_t q;
        bus_xfer(1'b1, idx, d, 4'hf, q);
    endtask : wr16

    task automatic rd16(input logic [14:0] idx, output bpcr_word_t q);
        bus_xfer(1'b0, idx, 16'h0, 4'hf, q);
    endtask : rd16

    // Let registered settings reach the decoded outputs
    task automatic settle();
        repeat (2) @(negedge sys_clk);
    endtask : settle

    task automatic load(input logic [1:0] c3, input logic [1:0] c4, input logic sl,
                        input logic [4:0] h3, input logic [4:0] h4);
        @(posedge sys_clk);
        cfg_load        <= 1'b1;
        cfg_conv3_cap   <= c3;
        cfg_conv4_cap   <= c4;
        cfg_conv4_slave <= sl;
        cfg_conv3_on_hi <= h3;
        cfg_conv4_on_hi <= h4;
        @(posedge sys_clk);
        cfg_load <= 1'b0;
        settle();
    endtask : load

    // Pulse the start inputs and count the cycles that each ramp stays busy
    task automatic ss_run(input logic [1:0] st, input logic [31:0] exp3,
                          input logic [31:0] exp4);
        int n3;
        int n4;
        n3 = 0;
        n4 = 0;
        @(posedge sys_clk);
        conv_start <= st;
        @(posedge sys_clk);
        conv_start <= 2'b00;
        for (int k = 0; k < 80; k++) begin
            @(negedge sys_clk);
            if (conv_ss_busy[0] === 1'b1) begin
                if (n3 == 0) chk("ss3_first_step", 32'h1, {30'h0, conv_ss_step[0]});
                n3++;
            end
            if (conv_ss_busy[1] === 1'b1) begin
                if (n4 == 0) chk("ss4_first_step", 32'h1, {30'h0, conv_ss_step[1]});
                n4++;
            end
        end
        chk("ss3_busy_cycles", exp3, 32'(n3));
        chk("ss4_busy_cycles", exp4, 32'(n4));
        chk("ss3_step_end", 32'h0, {30'h0, conv_ss_step[0]});
        chk("ss4_step_end", 32'h0, {30'h0, conv_ss_step[1]});
    endtask : ss_run

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        complete_run();
    end

    // Main sequence
    initial begin
        rstn = 1'b0; avs_address = 17'h0; avs_read = 1'b0; avs_write = 1'b0;
        avs_writedata = 32'h0; avs_byteenable = 4'h0; cfg_load = 1'b0;
        cfg_conv3_cap = 2'h0; cfg_conv4_cap = 2'h0; cfg_conv4_slave = 1'b0;
        cfg_conv3_on_hi = 5'h0; cfg_conv4_on_hi = 5'h0; conv_start = 2'h0;
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        rd16(`BPCR_IDX_C3_CTL1, rd); chk("c3_ctl1_reset", 32'h0014, rd);
        rd16(`BPCR_IDX_C4_CTL2, rd); chk("c4_ctl2_reset", 32'h0300, rd);
        chk("c3_ilim_reset", 32'h064, conv_ilim_ma[0]);
        chk("c4_on_reset", 32'h352, conv_on_mv[1]);
        // Locked key: limit bits and cap bits hold, bits 12 and 7:4 take the write
        wr16(`BPCR_IDX_C3_CTL1, 16'h10ff);
        rd16(`BPCR_IDX_C3_CTL1, rd); chk("c3_ctl1_locked", 32'h10f4, rd);
        wr16(`BPCR_IDX_KEY, 16'h5a3c);
        settle(); chk("key_open", 32'h1, key_unlocked);
        for (int i = 0; i < 4; i++) begin
            wr16(`BPCR_IDX_C3_CTL1, 16'(i << 2));
            rd16(`BPCR_IDX_C3_CTL1, rd); chk("c3_lim_rd", 32'(i << 2), rd);
            settle(); chk("c3_ilim", ilim_tab[i], conv_ilim_ma[0]);
        end
        // Slave bit is read-only to software
        wr16(`BPCR_IDX_C4_CTL1, 16'h2003);
        rd16(`BPCR_IDX_C4_CTL1, rd); chk("c4_ctl1_ro", 32'h0000, rd);
        chk("slave_ro", 32'h0, slave);
        // Low byte enable only, code 7Fh saturates
        bus_xfer(1'b1, `BPCR_IDX_C3_SLEEP, 16'hffff, 4'h1, rd);
        rd16(`BPCR_IDX_C3_SLEEP, rd); chk("c3_sleep_be", 32'h007f, rd);
        settle(); chk("sleep_sat", 32'hd48, conv_sleep_mv[0]);
        foreach (vcode[i]) begin
            wr16(`BPCR_IDX_C3_ON, {9'h0, vcode[i]});
            wr16(`BPCR_IDX_C3_SLEEP, {9'h0, vcode[i]});
            settle(); chk("on_mv", mv_of(vcode[i]), conv_on_mv[0]);
            chk("sleep_mv", mv_of(vcode[i]), conv_sleep_mv[0]);
        end
        // Configuration load sets upper code bits, cap ranges and the slave bit only
        wr16(`BPCR_IDX_C3_ON, 16'h0002);
        load(2'h2, 2'h3, 1'b0, 5'h05, 5'h1f);
        rd16(`BPCR_IDX_C3_ON, rd); chk("c3_on_load", 32'h0016, rd);
        chk("c3_on_mv_load", mv_of(7'h16), conv_on_mv[0]);
        rd16(`BPCR_IDX_C3_CTL1, rd); chk("c3_cap_load", 32'h2, rd & 16'h3);
        chk("cap3_out", 32'h2, cap3);
        chk("cap4_out", 32'h3, cap4);
        // Slave mode: converter four follows converter three
        wr16(`BPCR_IDX_C3_CTL2, 16'h0080);
        load(2'h1, 2'h3, 1'b1, 5'h05, 5'h1f);
        chk("slave_on", 32'h1, slave);
        chk("slave_cap4", 32'h1, cap4);
        chk("slave_ovp4", 32'h1, ovp4);
        chk("slave_on_mv4", mv_of(7'h16), conv_on_mv[1]);
        chk("slave_ilim4", 32'h190, conv_ilim_ma[1]);
        chk("slave_sleep_mv4", 32'hd48, conv_sleep_mv[1]);
        chk("ovp3_out", 32'h1, ovp3);
        load(2'h1, 2'h3, 1'b0, 5'h05, 5'h1f);
        chk("own_cap4", 32'h3, cap4);
        chk("own_ovp4", 32'h0, ovp4);
        chk("own_on_mv4", 32'hd48, conv_on_mv[1]);
        chk("own_ilim4", 32'h032, conv_ilim_ma[1]);
        chk("own_sleep_mv4", 32'h352, conv_sleep_mv[1]);
        // Soft-start codes, code 0 starts at once
        for (int s = 0; s < 4; s++) begin
            wr16(`BPCR_IDX_C3_CTL1, 16'(s << 4));
            settle();
            ss_run(2'b01, ss_exp[s], 32'h0);
        end
        // Converter four ramps on its own start, then on converter three's in slave mode
        wr16(`BPCR_IDX_C4_CTL1, 16'h0010);
        settle();
        ss_run(2'b10, 32'h0, 32'h0c);
        load(2'h1, 2'h3, 1'b1, 5'h05, 5'h1f);
        ss_run(2'b11, 32'h30, 32'h30);
        // Unmapped place reads zero
        wr16(15'h4068, 16'hffff);
        rd16(15'h4068, rd); chk("unmapped", 32'h0, rd);
        // Relocked key drops limit writes again
        wr16(`BPCR_IDX_KEY, 16'h0000);
        wr16(`BPCR_IDX_C3_CTL1, 16'h009c);
        rd16(`BPCR_IDX_C3_CTL1, rd); chk("c3_relocked", 32'h0091, rd);
        chk("key_closed", 32'h0, key_unlocked);
        complete_run();
    end
endmodule : bpcr_regs_tb
